/* rtl/spi_eeprom_select_control.v */
// Chip select, standby and self-timed write-cycle control of a serial EEPROM
//
// Overview of operation
// - The device is selected and answers serial traffic only while chip select is low.
// - With chip select high and no write cycle running the device sits in standby.
// - A started write cycle runs to its end whatever chip select does.
// - Chip select rising during a write cycle defers standby until the cycle ends.
// - Serial output is released to high impedance as soon as the device is deselected.
// - A write cycle starts only on the chip select rise that ends a valid write sequence.
// - Each write cycle finishes within 5 ms of its start.
// - After power-up serial activity is ignored until chip select has first been seen low.
// - Input bits are taken on rising serial clock, output changes after falling serial clock.
// - A write sequence is valid only if chip select rises right after a whole data byte.
// - The write enable latch clears when a write cycle finishes.
// - During a write cycle array reads are refused but status reads are allowed.
`timescale 1ns/1ps
`default_nettype none
`include "spi_eeprom_select_map.vh"
module spi_eeprom_select_control #(
  parameter [31:0] WRITE_CYCLES = `WRITE_CYCLE_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire chipSel_n,
  input wire serClk,
  input wire serIn,
  input wire [7:0] readData,
  output reg serOut,
  output reg serOutEn,
  output reg selected,
  output reg standby,
  output reg writeBusy,
  output reg writeStart,
  output reg write_enable_latch,
  output reg [7:0] opcode,
  output reg arrayReadGrant
);

  // ----------------------------------------------------------------
  // Opcode decoding
  // ----------------------------------------------------------------
  // Opcodes that end in a self-timed write cycle
  function isWriteOp;
    input [7:0] op;
    begin
      isWriteOp = (op == `OP_WRITE) || (op == `OP_WRSR);
    end
  endfunction

  // Fewest whole bytes that make a write sequence valid
  function [5:0] minWriteBytes;
    input [7:0] op;
    begin
      minWriteBytes = (op == `OP_WRITE) ? 6'h04 : 6'h02;
    end
  endfunction

  // Status reads stay open during a write cycle
  function isStatusRead;
    input [7:0] op;
    begin
      isStatusRead = (op == `OP_RDSR);
    end
  endfunction

  // Byte counts at which data leaves the device
  function isReadPhase;
    input [7:0] op;
    input [5:0] cnt;
    begin
      isReadPhase = ((op == `OP_READ) && (cnt >= 6'h03)) ||
        ((op == `OP_RDSR) && (cnt >= 6'h01));
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] csSync;
  reg [1:0] sckSync;
  reg [1:0] siSync;
  reg csQ;
  reg sckQ;
  wire csLow = ~csSync[1];
  wire sckRise = sckSync[1] & ~sckQ;
  wire sckFall = ~sckSync[1] & sckQ;
  wire csRise = csSync[1] & ~csQ;

  // Pins pass two flip-flops; edges come from the second stage
  always @(posedge clk) begin
    if (!rst_n) begin
      csSync <= 2'h3;
      sckSync <= 2'h0;
      siSync <= 2'h0;
      csQ <= 1'b1;
      sckQ <= 1'b0;
    end else begin
      csSync <= {csSync[0], chipSel_n};
      sckSync <= {sckSync[0], serClk};
      siSync <= {siSync[0], serIn};
      csQ <= csSync[1];
      sckQ <= sckSync[1];
    end
  end

  // ----------------------------------------------------------------
  // Power-up arming and serial counters
  // ----------------------------------------------------------------
  reg armed;
  reg [2:0] bitCnt;
  reg [5:0] byteCnt;
  reg [7:0] shiftIn;
  reg [7:0] shiftOut;
  reg byteDone;
  wire active = csLow & armed;
  wire [7:0] nextByte = {shiftIn[6:0], siSync[1]};

  // Counters only move while armed and selected
  always @(posedge clk) begin
    if (!rst_n) begin
      armed <= 1'b0;
      bitCnt <= 3'h0;
      byteCnt <= 6'h00;
      shiftIn <= 8'h00;
      byteDone <= 1'b0;
      opcode <= 8'h00;
    end else begin
      if (csLow)
        armed <= 1'b1;
      if (!csLow) begin
        bitCnt <= 3'h0;
        byteCnt <= 6'h00;
        byteDone <= 1'b0;
      end else if (active && sckRise) begin
        shiftIn <= nextByte;
        bitCnt <= bitCnt + 3'h1;
        byteDone <= (bitCnt == 3'h7);
        if (bitCnt == 3'h7) begin
          if (byteCnt != 6'h3f)
            byteCnt <= byteCnt + 6'h01;
          if (byteCnt == 6'h00)
            opcode <= nextByte;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Write cycle timer and latch
  // ----------------------------------------------------------------
  reg [31:0] timer;
  // A byte has just ended and no bit of the next has arrived
  wire byteEdge = byteDone && (bitCnt == 3'h0);
  wire wrSeqOk = isWriteOp(opcode) && write_enable_latch && byteEdge &&
    (byteCnt >= minWriteBytes(opcode));
  wire startNow = csRise && armed && !writeBusy && wrSeqOk;
  wire doneNow = writeBusy && (timer == 32'h0000_0001);

  // Timer counts the write cycle down to one, then clears busy and the latch
  always @(posedge clk) begin
    if (!rst_n) begin
      writeBusy <= 1'b0;
      writeStart <= 1'b0;
      timer <= 32'h0000_0000;
      write_enable_latch <= 1'b0;
    end else begin
      writeStart <= startNow;
      if (startNow) begin
        writeBusy <= 1'b1;
        timer <= WRITE_CYCLES;
      end else if (writeBusy) begin
        timer <= timer - 32'h0000_0001;
        if (doneNow)
          writeBusy <= 1'b0;
      end
      if (doneNow)
        write_enable_latch <= 1'b0;
      else if (csRise && armed && !writeBusy && byteEdge && (byteCnt == 6'h01)) begin
        if (opcode == `OP_WREN)
          write_enable_latch <= 1'b1;
        else if (opcode == `OP_WRDI)
          write_enable_latch <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Select state, standby and serial output
  // ----------------------------------------------------------------
  wire readPhase = isReadPhase(opcode, byteCnt);
  wire [7:0] statusByte = {6'h00, write_enable_latch, writeBusy};
  wire allowRead = readPhase && (isStatusRead(opcode) || !writeBusy);

  // Output changes one system clock after the synced serial clock falls
  always @(posedge clk) begin
    if (!rst_n) begin
      selected <= 1'b0;
      standby <= 1'b1;
      serOut <= 1'b0;
      serOutEn <= 1'b0;
      shiftOut <= 8'h00;
      arrayReadGrant <= 1'b0;
    end else begin
      selected <= active;
      standby <= !csLow && !writeBusy && !startNow;
      arrayReadGrant <= active && opcode == `OP_READ && byteCnt >= 6'h03 && !writeBusy;
      if (!active) begin
        serOutEn <= 1'b0;
        serOut <= 1'b0;
      end else if (sckFall && allowRead) begin
        serOutEn <= 1'b1;
        if (bitCnt == 3'h0) begin
          serOut <= isStatusRead(opcode) ? statusByte[7] : readData[7];
          shiftOut <= {(isStatusRead(opcode) ? statusByte[6:0] : readData[6:0]), 1'b0};
        end else begin
          serOut <= shiftOut[7];
          shiftOut <= {shiftOut[6:0], 1'b0};
        end
      end else if (sckFall) begin
        serOutEn <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/spi_eeprom_select_map.vh */
// Constants for the serial EEPROM select and write-cycle control block
`ifndef SPI_EEPROM_SELECT_MAP_VH
`define SPI_EEPROM_SELECT_MAP_VH
`define CLK_PERIOD_PS 5000
`define WRITE_CYCLE_MS 5
`define WRITE_CYCLE_CYCLES 32'd1000000
`define OP_WRITE 8'h02
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_READ 8'h03
`define OP_RDSR 8'h05
`define OP_WRSR 8'h01
`define ADDR_BITS 16
`endif

/* tb/spi_eeprom_select_properties.sv */
// Checker of the select, standby and write-cycle outputs
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_select_properties (
  input wire clk,
  input wire rst_n,
  input wire chipSel_n,
  input wire serOutEn,
  input wire selected,
  input wire standby,
  input wire writeBusy,
  input wire writeStart,
  input wire write_enable_latch,
  input wire arrayReadGrant
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sel_low_a: assert property (chipSel_n [*6] |-> !selected)
    else $error("selected while chip select high");
  idle_sb_a: assert property ((chipSel_n && !writeBusy) [*8] |-> standby)
    else $error("no standby while idle");
  busy_hold_a: assert property ($rose(writeBusy) |-> writeBusy [*8])
    else $error("write cycle cut short");
  busy_sb_a: assert property (writeBusy [*2] |-> !standby)
    else $error("standby during write cycle");
  so_off_a: assert property (chipSel_n [*6] |-> !serOutEn)
    else $error("output driven while deselected");
  start_ok_a: assert property (writeStart |-> chipSel_n && write_enable_latch)
    else $error("write start without cause");
  latch_clr_a: assert property ($fell(writeBusy) |-> ##[0:2] !write_enable_latch)
    else $error("latch kept after write");
  grant_a: assert property (writeBusy |-> !arrayReadGrant)
    else $error("array read during write");
endmodule
`default_nettype wire

/* tb/spi_host_model.sv */
// Host side model driving chip select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk,
  input wire logic serOut,
  output logic chipSel_n,
  output logic serClk,
  output logic serIn
);
  logic [31:0] rxData;
  initial begin
    rxData = 32'h0000_0000;
    chipSel_n = 1'b1;
    serClk = 1'b0;
    serIn = 1'b0;
  end
  // Selects first, shifts n bits MSB first, data set while clock low
  task automatic frame(input logic [31:0] d, input int n);
    chipSel_n <= 1'b0;
    repeat (32) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      serIn <= d[31-i];
      repeat (16) @(posedge clk);
      serClk <= 1'b1;
      rxData <= {rxData[30:0], serOut};
      repeat (16) @(posedge clk);
      serClk <= 1'b0;
    end
    repeat (16) @(posedge clk);
    chipSel_n <= 1'b1;
    serIn <= ~serIn;
    repeat (64) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb/spi_eeprom_select_control_test.sv */
// Testbench of the serial EEPROM select and write-cycle control
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_select_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire chipSel_n, serClk, serIn, serOut, serOutEn, selected, standby;
  wire writeBusy, writeStart, latch, grant;
  wire [7:0] opcode;
  int mismatches = 0, checks = 0, cycles = 0, starts = 0;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
  spi_host_model host_u (.clk(clk), .serOut(serOut), .chipSel_n(chipSel_n), .serClk(serClk),
    .serIn(serIn));
  spi_eeprom_select_control #(.WRITE_CYCLES(32'd3000)) dut_u (.clk(clk), .rst_n(rst_n),
    .chipSel_n(chipSel_n), .serClk(serClk), .serIn(serIn), .readData(8'h5a),
    .serOut(serOut), .serOutEn(serOutEn), .selected(selected), .standby(standby),
    .writeBusy(writeBusy), .writeStart(writeStart), .write_enable_latch(latch),
    .opcode(opcode), .arrayReadGrant(grant));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (writeStart === 1'b1) starts++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic write_test();
    `CHK(selected, 1'b0)
    `CHK(standby, 1'b1)
    host_u.frame(32'h0600_0000, 8);
    `CHK(latch, 1'b1)
    host_u.frame(32'h0200_10a5, 32);
    `CHK(starts, 1)
    `CHK(writeBusy, 1'b1)
    `CHK(standby, 1'b0)
    `CHK(serOutEn, 1'b0)
    host_u.frame(32'h0500_0000, 16);
    `CHK(host_u.rxData[7:0], 8'h03)
    host_u.frame(32'h0300_1000, 32);
    `CHK(host_u.rxData[7:0], 8'h00)
    `CHK(writeBusy, 1'b1)
    repeat (1300) @(posedge clk);
    `CHK(writeBusy, 1'b0)
    `CHK(latch, 1'b0)
    `CHK(standby, 1'b1)
    host_u.frame(32'h0300_1000, 32);
    `CHK(host_u.rxData[7:0], 8'h5a)
    `CHK(opcode, 8'h03)
    $display("write_test done");
  endtask
  task automatic abort_test();
    host_u.frame(32'h0600_0000, 8);
    host_u.frame(32'h0200_10a5, 29);
    `CHK(starts, 1)
    `CHK(writeBusy, 1'b0)
    `CHK(latch, 1'b1)
    $display("abort_test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    write_test();
    abort_test();
    stop_test();
  end
endmodule
bind spi_eeprom_select_control spi_eeprom_select_properties prop_u (.clk, .rst_n,
  .chipSel_n, .serOutEn, .selected, .standby, .writeBusy, .writeStart,
  .write_enable_latch, .arrayReadGrant);
`default_nettype wire
